/* verilog/sasc_pkg.sv */
// Shared constants and types for the converter sequencer control block
package sasc_pkg;

  // ==========================================================================
  // Geometry
  localparam int SASC_CHANNELS    = 8;
  localparam int SASC_CH_W        = 3;
  localparam int SASC_RES_W       = 12;
  localparam int SASC_SAMP_W      = 8;

  // ==========================================================================
  // Timing: converter clock is the system clock divided by SASC_DIV
  localparam int SASC_CLK_MHZ_X10 = 1000;       // 100.0 MHz
  localparam int SASC_MAX_MHZ_X10 = 145;        // 14.5 MHz converter ceiling
  localparam int SASC_CONV_CLKS   = 18;         // Least converter clocks per conversion
  // Divider so the converter clock never exceeds its ceiling (rounds up)
  localparam int SASC_DIV         = (SASC_CLK_MHZ_X10 + SASC_MAX_MHZ_X10 - 1) / SASC_MAX_MHZ_X10;
  localparam logic [7:0] SASC_DIV_LAST = 8'(SASC_DIV - 1);
  localparam logic [7:0] SASC_CONV_LAST = 8'(SASC_CONV_CLKS - 1);

  // ==========================================================================
  // Reference selection field
  localparam logic [1:0] SASC_REF_VDD     = 2'h0;
  localparam logic [1:0] SASC_REF_VDD_HLF = 2'h1;
  localparam logic [1:0] SASC_REF_BANDGAP = 2'h2;  // Nominal 1.024 V
  localparam logic [1:0] SASC_REF_EXT     = 2'h3;

  // Sequencer states
  typedef enum logic [1:0] {SASC_IDLE, SASC_SAMPLE, SASC_CONVERT} sasc_state_t;

  // Result word carried through the buffer
  typedef struct packed {
    logic [SASC_CH_W-1:0]  chan;
    logic [SASC_RES_W-1:0] value;
    logic                  range_err;
    logic                  scan_end;
  } sasc_result_t;

  // Analog front-end control
  typedef struct packed {
    logic [SASC_CH_W-1:0] chan;
    logic                 temp_sel;
    logic [1:0]           ref_sel;
    logic                 hold;
    logic                 convert;
  } sasc_afe_t;

endpackage

/* verilog/sasc_skid.sv */
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/10ps
module sasc_skid
  import sasc_pkg::*;
#(
  parameter int WIDTH = 17
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem_reg [2];
  logic             wr_ptr_reg;
  logic             rd_ptr_reg;
  logic [1:0]       count_reg;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Handshakes
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= 2'(count_reg + {1'b0, push} - {1'b0, pop});
    end
  end

  a_no_overfill: assert property (@(posedge clock) disable iff (rst) count_reg <= 2'h2)
    else $error("buffer holds more than two words");

endmodule

/* verilog/sasc_core.sv */
// Sequencer and control for a 12-bit eight-channel successive-approximation converter
`timescale 1ns/10ps
module sasc_core
  import sasc_pkg::*;
#(
  parameter int NCH   = SASC_CHANNELS,
  parameter int RES_W = SASC_RES_W,
  parameter int SAM_W = SASC_SAMP_W
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst,
  // Configuration
  input  wire logic                        enable,
  input  wire logic                        deep_sleep,
  input  wire logic                        fw_mode,
  input  wire logic [NCH-1:0]              chan_en,
  input  wire logic [SASC_CH_W-1:0]        fw_chan,
  input  wire logic                        fw_start,
  input  wire logic                        temp_sel,
  input  wire logic [1:0]                  ref_sel,
  input  wire logic [NCH*SAM_W-1:0]        samp_time,
  input  wire logic [RES_W-1:0]            limit_low,
  input  wire logic [RES_W-1:0]            limit_high,
  input  wire logic                        range_clear,
  input  wire logic [SASC_CH_W-1:0]        rd_chan,
  // Converter core
  output sasc_afe_t                        afe,
  input  wire logic                        conv_done,
  input  wire logic [RES_W-1:0]            conv_data,
  // Result stream
  output logic                             res_valid,
  input  wire logic                        res_ready,
  output sasc_result_t                     res_data,
  // Status
  output logic [RES_W-1:0]                 rd_value,
  output logic                             range_flag,
  output logic                             scan_done,
  output logic                             busy
);

  sasc_state_t           state_reg;
  logic [SASC_CH_W-1:0]  chan_reg;
  logic [7:0]            div_reg;
  logic [SAM_W+7:0]      cnt_reg;
  logic                  tick;
  logic                  active;
  logic [RES_W-1:0]      chres_reg [NCH];
  logic [RES_W-1:0]      rd_value_reg;
  logic                  range_reg;
  logic                  scan_done_reg;
  sasc_afe_t             afe_reg;
  logic                  hit_range;
  logic                  last_ch;
  logic [SASC_CH_W-1:0]  next_ch;
  logic [SASC_CH_W-1:0]  first_ch;
  logic                  buf_ready;
  logic                  buf_valid;
  sasc_result_t          buf_data;
  logic                  stage_load;

  // ==========================================================================
  // Converter clock enable derived by division, never above ceiling
  assign tick   = (div_reg == SASC_DIV_LAST);
  assign active = enable && !deep_sleep;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= tick ? 8'h00 : 8'(div_reg + 8'h01);
    end
  end

  // ==========================================================================
  // Channel walk: next enabled above current, and lowest enabled
  always_comb begin
    first_ch = '0;
    next_ch  = '0;
    last_ch  = 1'b1;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (chan_en[i]) first_ch = SASC_CH_W'(i);
    end
    for (int i = NCH - 1; i >= 0; i--) begin
      if (chan_en[i] && SASC_CH_W'(i) > chan_reg) begin
        next_ch = SASC_CH_W'(i);
        last_ch = 1'b0;
      end
    end
  end

  // Strict comparison; limit values themselves are in range
  assign hit_range = (conv_data < limit_low) || (conv_data > limit_high);

  // ==========================================================================
  // Sequencer state machine; sample counts in converter clocks
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= SASC_IDLE;
      chan_reg  <= '0;
      cnt_reg   <= '0;
    end else if (!active) begin
      state_reg <= SASC_IDLE;
    end else if (tick) begin
      unique case (state_reg)
        SASC_IDLE: begin
          if (fw_mode && fw_start) begin
            chan_reg  <= fw_chan;
            state_reg <= SASC_SAMPLE;
            cnt_reg   <= '0;
          end else if (!fw_mode && chan_en != '0) begin
            chan_reg  <= first_ch;
            state_reg <= SASC_SAMPLE;
            cnt_reg   <= '0;
          end
        end
        SASC_SAMPLE: begin
          // Per-channel aperture, at least one clock
          if (cnt_reg >= (SAM_W+8)'(samp_time[chan_reg*SAM_W +: SAM_W])) begin
            state_reg <= SASC_CONVERT;
            cnt_reg   <= '0;
          end else begin
            cnt_reg <= (SAM_W+8)'(cnt_reg + 1'b1);
          end
        end
        SASC_CONVERT: begin
          if (cnt_reg < (SAM_W+8)'(SASC_CONV_LAST)) begin
            cnt_reg <= (SAM_W+8)'(cnt_reg + 1'b1);
          end else if (conv_done && buf_ready) begin
            // In scan mode go straight to the next sample with no idle slot; firmware mode returns to idle
            cnt_reg <= '0;
            if (fw_mode) begin
              state_reg <= SASC_IDLE;
            end else begin
              chan_reg  <= last_ch ? first_ch : next_ch;
              state_reg <= (chan_en == '0) ? SASC_IDLE : SASC_SAMPLE;
            end
          end
        end
        default: state_reg <= SASC_IDLE;
      endcase
    end
  end

  logic finish;
  assign finish = active && tick && state_reg == SASC_CONVERT &&
                  cnt_reg >= (SAM_W+8)'(SASC_CONV_LAST) && conv_done && buf_ready;

  // ==========================================================================
  // Per-channel result store
  always_ff @(posedge clock) begin
    if (finish) chres_reg[chan_reg] <= conv_data;
    rd_value_reg <= chres_reg[rd_chan];
  end

  // Sticky range flag; a new hit wins over a clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      range_reg     <= 1'b0;
      scan_done_reg <= 1'b0;
    end else begin
      range_reg     <= (finish && hit_range) || (range_reg && !range_clear);
      scan_done_reg <= finish && !fw_mode && last_ch;
    end
  end

  // Front-end drive, registered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      afe_reg <= '0;
    end else begin
      afe_reg.chan     <= chan_reg;
      afe_reg.temp_sel <= temp_sel;
      afe_reg.ref_sel  <= ref_sel;
      afe_reg.hold     <= active && state_reg == SASC_CONVERT;
      afe_reg.convert  <= active && state_reg == SASC_CONVERT;
    end
  end

  // ==========================================================================
  // Result buffer toward the reader
  sasc_skid #(.WIDTH($bits(sasc_result_t))) u_buf (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (finish),
    .in_ready  (buf_ready),
    .in_data   ({chan_reg, conv_data, hit_range, !fw_mode && last_ch}),
    .out_valid (buf_valid),
    .out_ready (stage_load),
    .out_data  (buf_data)
  );

  // The buffer pops exactly when the output stage loads, so no word is repeated or lost
  assign stage_load = !res_valid || res_ready;

  // Output stage register keeps outputs straight from flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_data  <= '0;
    end else if (stage_load) begin
      res_valid <= buf_valid;
      res_data  <= buf_data;
    end
  end

  assign afe        = afe_reg;
  assign rd_value   = rd_value_reg;
  assign range_flag = range_reg;
  assign scan_done  = scan_done_reg;
  assign busy       = afe_reg.convert;

  // ==========================================================================
  // Checks
  a_range_sets: assert property (@(posedge clock) disable iff (rst)
    finish && hit_range |=> range_flag) else $error("range hit not flagged");
  a_range_strict: assert property (@(posedge clock) disable iff (rst)
    finish && conv_data == limit_low && limit_low <= limit_high && !range_reg |=> !range_flag)
    else $error("limit value flagged");
  a_range_sticky: assert property (@(posedge clock) disable iff (rst)
    range_flag && !range_clear && !finish |=> range_flag) else $error("flag lost");
  a_sleep_idle: assert property (@(posedge clock) disable iff (rst)
    deep_sleep |=> state_reg == SASC_IDLE) else $error("active in deep sleep");
  a_conv_length: assert property (@(posedge clock) disable iff (rst)
    $rose(state_reg == SASC_CONVERT) |-> !finish [*8]) else $error("conversion too short");
  a_scan_wrap: assert property (@(posedge clock) disable iff (rst)
    finish && !fw_mode && last_ch && chan_en != '0 |=> chan_reg == $past(first_ch))
    else $error("scan did not restart");
  a_no_gap: assert property (@(posedge clock) disable iff (rst)
    finish && !fw_mode && chan_en != '0 && active |=> state_reg == SASC_SAMPLE)
    else $error("idle slot between channels");
  a_fw_chan: assert property (@(posedge clock) disable iff (rst)
    active && tick && state_reg == SASC_IDLE && fw_mode && fw_start |=> chan_reg == $past(fw_chan))
    else $error("firmware channel not taken");

endmodule

/* tb/sasc_core_model.sv */
// Behavioural converter core that answers the sequencer's front-end control
`timescale 1ns/10ps
module sasc_core_model
  import sasc_pkg::*;
#(
  parameter logic [11:0] TEMP_VAL = 12'h5a3  // Arbitrary sensor reading
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Control from the sequencer
  input  wire sasc_afe_t   afe,
  input  wire logic        slow,
  input  wire logic [95:0] vals,
  // Answer to the sequencer
  output logic             conv_done,
  output logic [11:0]      conv_data
);
  logic [7:0]  cnt_reg;
  logic [11:0] junk_reg;
  // ==========================================================================
  // Done rises after a short or long delay and is held until convert drops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg   <= 8'h0;
      conv_done <= 1'b0;
    end else if (!afe.convert) begin
      cnt_reg   <= 8'h0;
      conv_done <= 1'b0;
    end else if (cnt_reg == (slow ? 8'hc8 : 8'h02)) begin
      conv_done <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h1;
    end
  end
  // Junk that flips every clock, so a stale word is never taken for a result
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      junk_reg <= 12'ha5a;
    end else begin
      junk_reg <= junk_reg ^ 12'hfff;
    end
  end
  assign conv_data = !conv_done ? junk_reg : afe.temp_sel ? TEMP_VAL : vals[afe.chan*12 +: 12];
endmodule

/* tb/sasc_core_tb.sv */
// Self-checking bench for the converter sequencer control block
`timescale 1ns/10ps
module sasc_core_tb
  import sasc_pkg::*;
  ;
  localparam logic [11:0] TEMP_VAL = 12'h5a3;  // Arbitrary sensor reading
  localparam logic [11:0] LO       = 12'h400;
  localparam logic [11:0] HI       = 12'hc00;
  logic         clock, rst, enable, deep_sleep, fw_mode, fw_start, temp_sel, range_clear;
  logic         res_ready, conv_done, res_valid, range_flag, scan_done, busy, slow, drain;
  logic [7:0]   chan_en;
  logic [2:0]   fw_chan, rd_chan;
  logic [1:0]   ref_sel;
  logic [63:0]  samp_time;
  logic [11:0]  limit_low, limit_high, conv_data, rd_value, v;
  logic [95:0]  vals;
  sasc_afe_t    afe;
  sasc_result_t res_data, exp_w;
  sasc_result_t exp_q[$];
  int           fails, comparisons, cyc, lat, hold, seed, last, s, scan_ends;

  // ==========================================================================
  // Design and converter model
  sasc_core dut (.clock(clock), .rst(rst), .enable(enable), .deep_sleep(deep_sleep), .fw_mode(fw_mode),
    .chan_en(chan_en), .fw_chan(fw_chan), .fw_start(fw_start), .temp_sel(temp_sel), .ref_sel(ref_sel),
    .samp_time(samp_time), .limit_low(limit_low), .limit_high(limit_high), .range_clear(range_clear),
    .rd_chan(rd_chan), .afe(afe), .conv_done(conv_done), .conv_data(conv_data), .res_valid(res_valid),
    .res_ready(res_ready), .res_data(res_data), .rd_value(rd_value), .range_flag(range_flag),
    .scan_done(scan_done), .busy(busy));
  sasc_core_model #(.TEMP_VAL(TEMP_VAL)) model (.clock(clock), .rst(rst), .afe(afe), .slow(slow),
    .vals(vals), .conv_done(conv_done), .conv_data(conv_data));

  // ==========================================================================
  // Clock, random receiver stalls and hang guard
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    #1;
    res_ready = drain | 1'($random(seed));
  end
  always @(posedge clock) begin
    cyc++;
    if (scan_done === 1'b1) scan_ends++;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end

  // ==========================================================================
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic err(input logic [11:0] x);
    return x < LO || x > HI;
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Scoreboard: oldest note is compared with each word taken off the stream
  always @(posedge clock) begin
    if (res_valid === 1'b1 && res_ready === 1'b1 && exp_q.size() > 0) begin
      exp_w = exp_q.pop_front();
      check(32'(res_data), 32'(exp_w));
      if (exp_w.range_err) check(32'(range_flag), 32'h1);
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 84;
    {rst, enable, deep_sleep, fw_mode, fw_start, temp_sel, range_clear, slow, drain} = 9'h100;
    {fw_chan, rd_chan, ref_sel} = 8'h0;
    limit_low = LO;
    limit_high = HI;
    for (int i = 0; i < 8; i++) begin
      vals[i*12 +: 12] = 12'($random(seed));
      samp_time[i*8 +: 8] = 8'($random(seed)) & 8'h1f;
    end
    // Both limits themselves are in range, one below the low limit is not
    vals[35:0] = {LO - 12'h1, HI, LO};
    samp_time[7:0] = 8'h0;
    chan_en = 8'($random(seed)) | 8'h07;
    for (int c = 0; c < 8; c++) if (chan_en[c]) last = c;
    step(10);
    rst = 1'b0;
    // Two autonomous scans, ascending, each closed by the last enabled channel
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 8; c++)
        if (chan_en[c]) exp_q.push_back({3'(c), vals[c*12 +: 12], err(vals[c*12 +: 12]), 1'(c == last)});
    step(1);
    enable = 1'b1;
    while (exp_q.size() > 0) step(1);
    check(scan_ends, 2);
    check(32'(range_flag), 32'h1);
    for (int c = 0; c < 3; c++) begin
      rd_chan = 3'(c);
      step(3);
      check(32'(rd_value), 32'(vals[c*12 +: 12]));
    end
    // Deep sleep stops the scan mid-run and keeps it stopped
    deep_sleep = 1'b1;
    drain = 1'b1;
    step(10);
    hold = 0;
    for (int i = 0; i < 300; i++) begin
      hold += int'(busy !== 1'b0);
      step(1);
    end
    check(hold, 0);
    range_clear = 1'b1;
    step(2);
    range_clear = 1'b0;
    step(1);
    check(32'(range_flag), 32'h0);
    enable = 1'b0;
    deep_sleep = 1'b0;
    step(20);
    // Firmware picks every channel, every reference code and the sensor once
    drain = 1'b0;
    fw_mode = 1'b1;
    enable = 1'b1;
    step(1);
    for (int c = 0; c < 8; c++) begin
      ref_sel = 2'(c);
      temp_sel = (c == 7);
      slow = 1'(c);
      fw_chan = 3'(c);
      s = int'(samp_time[c*8 +: 8]);
      v = temp_sel ? TEMP_VAL : vals[c*12 +: 12];
      exp_q.push_back({3'(c), v, err(v), 1'b0});
      fw_start = 1'b1;
      lat = 0;
      while (busy !== 1'b1 && lat < 2000) begin
        step(1);
        lat++;
      end
      fw_start = 1'b0;
      check(32'(lat >= (s + 1) * 7 - 1 && lat <= (s + 1) * 7 + 14), 32'h1);
      check(32'(afe.chan), 32'(c));
      check(32'(afe.hold), 32'h1);
      check(32'(afe.ref_sel), 32'(c % 4));
      check(32'(afe.temp_sel), 32'(temp_sel));
      hold = 0;
      while (busy === 1'b1 && hold < 5000) begin
        step(1);
        hold++;
      end
      check(32'(hold >= 126), 32'h1);
      while (exp_q.size() > 0) step(1);
    end
    give_verdict();
  end
endmodule
